// file: verilog/pph_parallel_port.sv
`timescale 1ns/1ps
module pph_parallel_port (
  // Clock and reset
  input  wire logic                                 CLK,
  input  wire logic                                 RST_N,
  input  wire logic                                 CKE,
  // Host bus
  input  wire logic                                 CE_N,
  input  wire logic                                 BA_SEL,
  input  wire logic                                 CD_SEL,
  input  wire logic                                 M1_N,
  input  wire logic                                 IO_REQUEST_STROBE_N,
  input  wire logic                                 RD_N,
  input  wire logic [7:0]                           D_IN,
  output logic      [7:0]                           D_OUT,
  output logic                                      D_OE,
  // Interrupt chain
  output logic                                      INT_OUT,
  output logic                                      INT_OE,
  input  wire logic                                 CHAIN_ENABLE_IN,
  output logic                                      CHAIN_ENABLE_OUT,
  // Peripheral ports, index 0 is port A
  input  wire pph_pkg::pph_pin_in_type [pph_pkg::NPORT-1:0]  PORT_IN,
  output pph_pkg::pph_pin_out_type     [pph_pkg::NPORT-1:0]  PORT_OUT
);
  // ====================================================================
  // State
  pph_pkg::pph_state_type s_q;
  pph_pkg::pph_state_type s_d;
  logic [pph_pkg::NPORT:0]   chain;
  logic [pph_pkg::NPORT-1:0] int_bit;
  logic                      io_act;
  logic                      bi_a;

  assign io_act = ~CE_N & ~IO_REQUEST_STROBE_N & M1_N;
  assign bi_a   = s_q.port[pph_pkg::PORT_A].mode == pph_pkg::MODE_BI;

  // ====================================================================
  // Daisy chain and pin outputs
  assign chain[0] = CHAIN_ENABLE_IN;
  generate
    for (genvar g = 0; g < pph_pkg::NPORT; g++) begin : g_port
      // Combinational ripple keeps chain delay to one gate per port
      assign chain[g+1] = chain[g] & ~s_q.port[g].ius &
                          ~(s_q.port[g].ip & s_q.port[g].ie & ~s_q.ed);
      assign int_bit[g] = chain[g] & s_q.port[g].ip & s_q.port[g].ie & ~s_q.port[g].ius;
      assign PORT_OUT[g].ready = s_q.port[g].rdy & ~s_q.port[g].force_lo &
                                 ((s_q.port[g].mode != pph_pkg::MODE_BIT) |
                                  ((g == pph_pkg::PORT_B) & bi_a));
      assign PORT_OUT[g].data  = s_q.port[g].outr;
      assign PORT_OUT[g].oe    = (s_q.port[g].mode == pph_pkg::MODE_OUT) ? pph_pkg::ALL_ONES :
                                 (s_q.port[g].mode == pph_pkg::MODE_BIT) ? ~s_q.port[g].dir :
                                 ((s_q.port[g].mode == pph_pkg::MODE_BI) & ~PORT_IN[g].strobe_n) ?
                                 pph_pkg::ALL_ONES : pph_pkg::ALL_ZEROS;
    end
  endgenerate
  assign CHAIN_ENABLE_OUT = chain[pph_pkg::NPORT];
  assign INT_OUT          = 1'b0;
  assign INT_OE           = |int_bit;
  assign D_OUT            = s_q.dout;
  assign D_OE             = s_q.doe;

  // ====================================================================
  // Next state
  always_comb begin
    logic       pi;
    logic       hi;
    logic       return_from_irq_opcode;
    logic       m1_rise;
    logic       hit;
    logic       rise;
    logic       eq;
    logic [7:0] val;
    logic [7:0] lvl;
    pi      = BA_SEL;
    hi      = BA_SEL;
    return_from_irq_opcode    = 1'b0;
    hit     = 1'b0;
    rise    = 1'b0;
    eq      = 1'b0;
    val     = pph_pkg::ALL_ZEROS;
    lvl     = pph_pkg::ALL_ZEROS;
    s_d     = s_q;
    m1_rise = s_q.m1_q & M1_N;
    s_d.io_q = io_act;
    s_d.m1_q = ~M1_N;

    // Opcode watch for the return sequence
    if (~M1_N & ~RD_N & IO_REQUEST_STROBE_N) begin
      s_d.opc = D_IN;
    end
    if (m1_rise) begin
      return_from_irq_opcode         = s_q.ed & (s_q.opc == pph_pkg::OPC_RETURN_FROM_IRQ_OPCODE);
      s_d.ed       = (s_q.opc == pph_pkg::OPC_PREFIX) & ~s_q.ack_seen;
      s_d.ack_seen = 1'b0;
    end
    if (~M1_N & ~IO_REQUEST_STROBE_N) begin
      s_d.ack_seen = 1'b1;
    end

    // Host access start
    if (io_act & ~s_q.io_q) begin
      hi     = (~BA_SEL & bi_a & ~RD_N) ? pph_pkg::PORT_B : BA_SEL;
      s_d.wr_q = RD_N;
      s_d.dq   = ~CD_SEL;
      s_d.pq   = pi;
      s_d.hq   = hi;
      if (~CD_SEL) begin
        if (RD_N) begin
          s_d.port[pi].outr = D_IN;
        end
        if (s_q.port[hi].rdy) begin
          s_d.port[hi].force_lo = 1'b1;
        end
      end else if (RD_N) begin
        case (s_q.port[pi].expect_w)
          pph_pkg::EXP_DIR: begin
            s_d.port[pi].dir      = D_IN;
            s_d.port[pi].expect_w = pph_pkg::EXP_NONE;
          end
          pph_pkg::EXP_MASK: begin
            s_d.port[pi].mask     = D_IN;
            s_d.port[pi].arm      = s_q.port[pi].en_want;
            s_d.port[pi].expect_w = pph_pkg::EXP_NONE;
          end
          default: begin
            if (D_IN[pph_pkg::ID_MSB:0] == pph_pkg::ID_MODE) begin
              // Port B refuses bidirectional, it has no spare handshake
              if (!(pi == pph_pkg::PORT_B && D_IN[pph_pkg::MODE_MSB:pph_pkg::MODE_LSB] == pph_pkg::MODE_BI)) begin
                s_d.port[pi].mode = D_IN[pph_pkg::MODE_MSB:pph_pkg::MODE_LSB];
                if (D_IN[pph_pkg::MODE_MSB:pph_pkg::MODE_LSB] == pph_pkg::MODE_BIT) begin
                  s_d.port[pi].expect_w = pph_pkg::EXP_DIR;
                end
              end
            end else if (D_IN[pph_pkg::ID_MSB:0] == pph_pkg::ID_ICW) begin
              s_d.port[pi].and_or  = D_IN[pph_pkg::BIT_AND];
              s_d.port[pi].hi_lo   = D_IN[pph_pkg::BIT_HIGH];
              s_d.port[pi].en_want = D_IN[pph_pkg::BIT_EN];
              s_d.port[pi].arm     = D_IN[pph_pkg::BIT_EN] & ~D_IN[pph_pkg::BIT_MASKF];
              if (!D_IN[pph_pkg::BIT_EN]) begin
                s_d.port[pi].ie = 1'b0;
              end
              if (D_IN[pph_pkg::BIT_MASKF]) begin
                s_d.port[pi].ip       = 1'b0;
                s_d.port[pi].ev       = 1'b0;
                s_d.port[pi].expect_w = pph_pkg::EXP_MASK;
              end
            end else if (D_IN[pph_pkg::IE_ONLY_MSB:0] == pph_pkg::ID_IE_ONLY) begin
              s_d.port[pi].arm = D_IN[pph_pkg::BIT_EN];
              if (!D_IN[pph_pkg::BIT_EN]) begin
                s_d.port[pi].ie = 1'b0;
              end
            end else if (!D_IN[pph_pkg::BIT_VEC]) begin
              s_d.port[pi].vec = D_IN;
            end
          end
        endcase
      end
    end

    // Host access end
    if (~io_act & s_q.io_q & s_q.dq) begin
      s_d.port[s_q.hq].force_lo = 1'b0;
      if (s_q.wr_q) begin
        if (s_q.port[s_q.hq].mode == pph_pkg::MODE_OUT || s_q.port[s_q.hq].mode == pph_pkg::MODE_BI) begin
          s_d.port[s_q.hq].rdy = 1'b1;
        end
      end else if (s_q.port[s_q.pq].mode == pph_pkg::MODE_IN ||
                   (s_q.pq == pph_pkg::PORT_A && bi_a)) begin
        s_d.port[s_q.hq].full = 1'b0;
        s_d.port[s_q.hq].rdy  = 1'b1;
      end
    end

    // Read data and acknowledge vector, both from flops
    s_d.doe = 1'b0;
    if (io_act & ~RD_N & ~CD_SEL) begin
      s_d.doe = 1'b1;
      case (s_q.port[pi].mode)
        pph_pkg::MODE_OUT: s_d.dout = s_q.port[pi].outr;
        pph_pkg::MODE_BIT: s_d.dout = (s_q.port[pi].outr & ~s_q.port[pi].dir) |
                                      (s_q.port[pi].inr & s_q.port[pi].dir);
        default:           s_d.dout = s_q.port[pi].inr;
      endcase
    end
    s_d.ackv = 1'b0;
    if (~M1_N & ~IO_REQUEST_STROBE_N) begin
      s_d.ackv = s_q.ackv;
      if (!s_q.ackv) begin
        for (int k = 0; k < pph_pkg::NPORT; k++) begin
          if (!hit && chain[k] && int_bit[k]) begin
            hit             = 1'b1;
            s_d.dout        = s_q.port[k].vec;
            s_d.port[k].ius = 1'b1;
            s_d.port[k].ip  = 1'b0;
          end
        end
        s_d.ackv = hit;
      end
      s_d.doe = s_d.ackv;
    end

    // Per-port handshake and interrupt events
    for (int k = 0; k < pph_pkg::NPORT; k++) begin
      rise             = s_q.port[k].stb_q & PORT_IN[k].strobe_n;
      s_d.port[k].stb_q = ~PORT_IN[k].strobe_n;
      // An event while a request is pending merges into it, none is queued
      if (M1_N && s_q.port[k].ev) begin
        s_d.port[k].ip = 1'b1;
        s_d.port[k].ev = 1'b0;
      end
      if (return_from_irq_opcode && chain[k] && s_q.port[k].ius) begin
        s_d.port[k].ius = 1'b0;
      end
      if (m1_rise && !s_q.ack_seen && s_q.port[k].arm) begin
        s_d.port[k].ie  = 1'b1;
        s_d.port[k].arm = 1'b0;
      end
      s_d.port[k].eq_q = 1'b0;
      case (s_q.port[k].mode)
        pph_pkg::MODE_OUT: begin
          if (rise) begin
            s_d.port[k].rdy = 1'b0;
            s_d.port[k].ev  = 1'b1;
          end
        end
        pph_pkg::MODE_IN: begin
          if (~PORT_IN[k].strobe_n & ~s_q.port[k].full) begin
            s_d.port[k].inr = PORT_IN[k].data;
          end
          if (rise) begin
            s_d.port[k].full = 1'b1;
            s_d.port[k].rdy  = 1'b0;
            s_d.port[k].ev   = 1'b1;
          end
        end
        pph_pkg::MODE_BI: begin
          if (rise) begin
            s_d.port[k].rdy = 1'b0;
            s_d.port[k].ev  = 1'b1;
          end
          if (~PORT_IN[pph_pkg::PORT_B].strobe_n & ~s_q.port[pph_pkg::PORT_B].full) begin
            s_d.port[k].inr = PORT_IN[k].data;
          end
        end
        default: begin
          if (RD_N) begin
            s_d.port[k].inr = PORT_IN[k].data;
          end
          val = (s_q.port[k].outr & ~s_q.port[k].dir) | (PORT_IN[k].data & s_q.port[k].dir);
          lvl = s_q.port[k].hi_lo ? val : ~val;
          eq  = s_q.port[k].and_or ? ((&(lvl | s_q.port[k].mask)) & ~(&s_q.port[k].mask)) :
                                     (|(lvl & ~s_q.port[k].mask));
          s_d.port[k].eq_q = eq;
          if (eq && !s_q.port[k].eq_q && s_q.port[k].ie) begin
            s_d.port[k].ev = 1'b1;
          end
          // B input half of a bidirectional A shares B's flags and vector
          if (k == pph_pkg::PORT_B && bi_a && rise) begin
            s_d.port[k].full = 1'b1;
            s_d.port[k].rdy  = 1'b0;
            s_d.port[k].ev   = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q <= pph_pkg::STATE_RST;
    end else if (CKE) begin
      s_q <= s_d;
    end
  end
endmodule : pph_parallel_port

// file: verilog/pph_pkg.sv
// ======================================================================
// Shared constants and types
package pph_pkg;
  localparam int          NPORT      = 2;
  localparam logic        PORT_A     = 1'b0;
  localparam logic        PORT_B     = 1'b1;
  localparam logic [1:0]  MODE_OUT   = 2'h0;
  localparam logic [1:0]  MODE_IN    = 2'h1;
  localparam logic [1:0]  MODE_BI    = 2'h2;
  localparam logic [1:0]  MODE_BIT   = 2'h3;
  localparam logic [3:0]  ID_MODE    = 4'hF;
  localparam logic [3:0]  ID_ICW     = 4'h7;
  localparam logic [3:0]  ID_IE_ONLY = 4'h3;
  localparam int          ID_MSB     = 3;
  localparam int          IE_ONLY_MSB = 3;
  localparam int          MODE_MSB   = 7;
  localparam int          MODE_LSB   = 6;
  localparam int          BIT_EN     = 7;
  localparam int          BIT_AND    = 6;
  localparam int          BIT_HIGH   = 5;
  localparam int          BIT_MASKF  = 4;
  localparam int          BIT_VEC    = 0;
  localparam logic [7:0]  OPC_PREFIX = 8'hED;
  localparam logic [7:0]  OPC_RETURN_FROM_IRQ_OPCODE   = 8'h4D;
  localparam logic [7:0]  ALL_ONES   = 8'hFF;
  localparam logic [7:0]  ALL_ZEROS  = 8'h00;

  typedef enum logic [1:0] {EXP_NONE, EXP_DIR, EXP_MASK} pph_expect_type;

  typedef struct packed {
    logic       strobe_n;
    logic [7:0] data;
  } pph_pin_in_type;

  typedef struct packed {
    logic       ready;
    logic [7:0] data;
    logic [7:0] oe;
  } pph_pin_out_type;

  typedef struct packed {
    logic [1:0]     mode;
    logic [7:0]     outr;
    logic [7:0]     inr;
    logic [7:0]     dir;
    logic [7:0]     mask;
    logic [7:0]     vec;
    pph_expect_type expect_w;
    logic           ie;
    logic           arm;
    logic           en_want;
    logic           and_or;
    logic           hi_lo;
    logic           rdy;
    logic           full;
    logic           force_lo;
    logic           ev;
    logic           ip;
    logic           ius;
    logic           eq_q;
    logic           stb_q;
  } pph_port_type;

  typedef struct packed {
    pph_port_type [NPORT-1:0] port;
    logic       io_q;
    logic       wr_q;
    logic       dq;
    logic       pq;
    logic       hq;
    logic       m1_q;
    logic       ack_seen;
    logic       ackv;
    logic       ed;
    logic [7:0] opc;
    logic [7:0] dout;
    logic       doe;
  } pph_state_type;

  localparam pph_port_type PORT_RST = '{mode: MODE_IN, mask: ALL_ONES, dir: ALL_ONES,
                                        expect_w: EXP_NONE, default: '0};
  localparam pph_state_type STATE_RST = '{port: '{PORT_RST, PORT_RST}, default: '0};
endpackage : pph_pkg

// file: verification/pph_parallel_port_assertions.sv
`timescale 1ns/1ps
// ====================================================================
// Port-level checks of the parallel port
module pph_parallel_port_assertions (
  // Clock and reset
  input wire logic                                        CLK,
  input wire logic                                        RST_N,
  // Host bus
  input wire logic                                        CE_N,
  input wire logic                                        BA_SEL,
  input wire logic                                        CD_SEL,
  input wire logic                                        M1_N,
  input wire logic                                        IO_REQUEST_STROBE_N,
  input wire logic                                        RD_N,
  input wire logic                                        D_OE,
  // Interrupt chain
  input wire logic                                        INT_OE,
  input wire logic                                        CHAIN_ENABLE_IN,
  input wire logic                                        CHAIN_ENABLE_OUT,
  // Peripheral ports
  input wire pph_pkg::pph_pin_in_type  [pph_pkg::NPORT-1:0] PORT_IN,
  input wire pph_pkg::pph_pin_out_type [pph_pkg::NPORT-1:0] PORT_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic cause;
  // A host read or an acknowledge is the only thing that may open the data bus
  assign cause = !IO_REQUEST_STROBE_N && (!M1_N || (!RD_N && !CE_N));
  sequence s_wr_a;
    !CE_N && !IO_REQUEST_STROBE_N && M1_N && RD_N && !BA_SEL && !CD_SEL;
  endsequence
  sequence s_fetch;
    !M1_N && IO_REQUEST_STROBE_N;
  endsequence
  property p_chain;    !CHAIN_ENABLE_IN |-> !CHAIN_ENABLE_OUT; endproperty
  property p_stable;   s_fetch ##1 s_fetch |-> $stable(INT_OE); endproperty
  property p_force;    s_wr_a ##1 s_wr_a |-> !PORT_OUT[0].ready; endproperty
  property p_rise;     $rose(PORT_OUT[0].ready) |-> $past(IO_REQUEST_STROBE_N); endproperty
  property p_drop_a;   $rose(PORT_IN[0].strobe_n) |-> ##[1:2] !PORT_OUT[0].ready; endproperty
  property p_drop_b;   $rose(PORT_IN[1].strobe_n) |-> ##[1:2] !PORT_OUT[1].ready; endproperty
  property p_hold;     $rose(PORT_IN[0].strobe_n) |-> $stable(PORT_OUT[0].data); endproperty
  property p_answer;   D_OE |-> $past(cause); endproperty
  property p_service;  D_OE && !M1_N |-> !CHAIN_ENABLE_OUT; endproperty
  a_chain: assert property (p_chain) else $error("chain out high with chain in low");
  a_stable: assert property (p_stable) else $error("request changed during fetch");
  a_force: assert property (p_force) else $error("ready high during port write");
  a_rise: assert property (p_rise) else $error("ready rose during an access");
  a_drop_a: assert property (p_drop_a) else $error("port A ready kept after strobe");
  a_drop_b: assert property (p_drop_b) else $error("port B ready kept after strobe");
  a_hold: assert property (p_hold) else $error("output data moved at strobe end");
  a_answer: assert property (p_answer) else $error("data bus driven without cause");
  a_service: assert property (p_service) else $error("vector given with chain out high");
endmodule : pph_parallel_port_assertions

bind pph_parallel_port pph_parallel_port_assertions i_chk (
  .CLK(CLK), .RST_N(RST_N), .CE_N(CE_N), .BA_SEL(BA_SEL), .CD_SEL(CD_SEL), .M1_N(M1_N),
  .IO_REQUEST_STROBE_N(IO_REQUEST_STROBE_N), .RD_N(RD_N), .D_OE(D_OE), .INT_OE(INT_OE), .CHAIN_ENABLE_IN(CHAIN_ENABLE_IN),
  .CHAIN_ENABLE_OUT(CHAIN_ENABLE_OUT), .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT));

// file: verification/pph_peripheral_model.sv
`timescale 1ns/1ps
// ====================================================================
// Strobed peripheral on both ports
module pph_peripheral_model (
  // Clock
  input wire logic                              clk,
  // Commands from the bench
  input wire logic                              go,
  input wire logic                              sel,
  input wire logic                              slow,
  input wire logic                              bidir,
  input wire logic [7:0]                        val,
  // Port pins
  input wire pph_pkg::pph_pin_out_type [1:0]    pin_o,
  output pph_pkg::pph_pin_in_type      [1:0]    pin_i,
  output logic [7:0]                            seen
);
  logic [1:0] stb_n = 2'h3;
  logic [2:0] cnt   = 3'h0;
  logic [7:0] last  = 8'h00;
  logic [7:0] ext;
  // No pull-ups: a released line shows the inverse of its last value
  assign ext = (bidir && stb_n[1]) ? ~last : val;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      pin_i[k].strobe_n = stb_n[k];
      pin_i[k].data = (pin_o[k].oe & pin_o[k].data) | (~pin_o[k].oe & (k == 0 ? ext : val));
    end
  end
  always_ff @(posedge clk) begin
    if (!stb_n[1]) begin
      last <= val;
    end
    if (go && cnt == 3'h0) begin
      stb_n[sel] <= 1'b0;
      cnt <= slow ? 3'h4 : 3'h1;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        stb_n <= 2'h3;
        seen <= pin_i[0].data;
      end
    end
  end
endmodule : pph_peripheral_model

// file: verification/pph_parallel_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
// ====================================================================
// Bench for the parallel port
module pph_parallel_port_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, ce_n = 1'b1, ba = 1'b0, cd = 1'b0, m1_n = 1'b1, io_request_strobe_n = 1'b1;
  logic rd_n = 1'b1, ch_in = 1'b1, go = 1'b0, sel = 1'b0, slow = 1'b0, bidir = 1'b0;
  logic [7:0] d_in = 8'h00, val = 8'h00, seen, d_out, q;
  logic d_oe, int_oe, ch_out;
  pph_pkg::pph_pin_in_type  [1:0] p_in;
  pph_pkg::pph_pin_out_type [1:0] p_out;
  int fail_count = 0, compares = 0;
  pph_parallel_port i_dut (.CLK(clk), .RST_N(rst_n), .CKE(1'b1), .CE_N(ce_n), .BA_SEL(ba), .CD_SEL(cd),
    .M1_N(m1_n), .IO_REQUEST_STROBE_N(io_request_strobe_n), .RD_N(rd_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .INT_OUT(),
    .INT_OE(int_oe), .CHAIN_ENABLE_IN(ch_in), .CHAIN_ENABLE_OUT(ch_out), .PORT_IN(p_in), .PORT_OUT(p_out));
  pph_peripheral_model i_per (.clk(clk), .go(go), .sel(sel), .slow(slow), .bidir(bidir), .val(val),
    .pin_o(p_out), .pin_i(p_in), .seen(seen));
  initial forever #5 clk = ~clk;
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Request held three edges so a read answer is taken before release
  task io(input logic rd, input logic b, input logic c, input logic [7:0] d);
    @(posedge clk);
    {ce_n, io_request_strobe_n, rd_n, ba, cd, d_in} <= {2'b00, ~rd, b, c, d};
    tick(2);
    q = d_out;
    @(posedge clk);
    {ce_n, io_request_strobe_n, rd_n} <= 3'b111;
    tick(1);
  endtask : io
  task fetch(input logic [7:0] op);
    @(posedge clk);
    {m1_n, rd_n, d_in} <= {2'b00, op};
    tick(2);
    @(posedge clk);
    {m1_n, rd_n} <= 2'b11;
    tick(2);
  endtask : fetch
  task ack;
    @(posedge clk);
    m1_n <= 1'b0;
    @(posedge clk);
    io_request_strobe_n <= 1'b0;
    tick(2);
    q = d_out;
    `CHK(d_oe, 1'b1)
    @(posedge clk);
    {m1_n, io_request_strobe_n} <= 2'b11;
    tick(1);
  endtask : ack
  task strobe(input logic s, input logic w, input logic [7:0] v);
    @(posedge clk);
    {go, sel, slow, val} <= {1'b1, s, w, v};
    @(posedge clk);
    go <= 1'b0;
    tick(7);
  endtask : strobe
  task end_of_test;
    $display("Counts: %0d mismatches in %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    #50000;
    fail_count++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ch_in <= 1'b0;
    tick(2);
    `CHK(ch_out, 1'b0)
    @(posedge clk) ch_in <= 1'b1;
    io(1'b1, 1'b0, 1'b0, 8'h00);
    tick(1);
    `CHK(p_out[0].ready, 1'b1)
    strobe(1'b0, 1'b0, 8'h5A);
    `CHK(p_out[0].ready, 1'b0)
    io(1'b0, 1'b0, 1'b1, 8'h20);
    io(1'b0, 1'b0, 1'b1, 8'h87);
    io(1'b1, 1'b0, 1'b0, 8'h00);
    `CHK(q, 8'h5A)
    strobe(1'b0, 1'b0, 8'h3C);
    `CHK(int_oe, 1'b0)
    fetch(8'h00);
    `CHK(int_oe, 1'b1)
    ack;
    `CHK(q, 8'h20)
    `CHK(ch_out, 1'b0)
    fetch(8'hED);
    fetch(8'h4D);
    `CHK(ch_out, 1'b1)
    io(1'b0, 1'b0, 1'b1, 8'h03);
    io(1'b0, 1'b0, 1'b1, 8'h0F);
    io(1'b0, 1'b0, 1'b0, 8'h96);
    tick(1);
    `CHK(p_out[0].ready, 1'b1)
    io(1'b0, 1'b0, 1'b0, 8'h69);
    strobe(1'b0, 1'b0, 8'h00);
    `CHK(p_out[0].ready, 1'b0)
    io(1'b0, 1'b0, 1'b1, 8'h8F);
    io(1'b0, 1'b1, 1'b1, 8'hCF);
    io(1'b0, 1'b1, 1'b1, 8'hFF);
    io(1'b0, 1'b0, 1'b0, 8'hA5);
    `CHK(p_out[0].oe, 8'h00)
    @(posedge clk) bidir <= 1'b1;
    strobe(1'b0, 1'b1, 8'h00);
    `CHK(seen, 8'hA5)
    io(1'b1, 1'b0, 1'b0, 8'h00);
    tick(1);
    `CHK(p_out[1].ready, 1'b1)
    strobe(1'b1, 1'b0, 8'hC3);
    io(1'b1, 1'b0, 1'b0, 8'h00);
    `CHK(q, 8'hC3)
    @(posedge clk) bidir <= 1'b0;
    io(1'b0, 1'b0, 1'b1, 8'h4F);
    io(1'b0, 1'b1, 1'b1, 8'hCF);
    io(1'b0, 1'b1, 1'b1, 8'h0F);
    io(1'b0, 1'b1, 1'b0, 8'hA0);
    @(posedge clk) val <= 8'h04;
    io(1'b1, 1'b1, 1'b0, 8'h00);
    `CHK(q, 8'hA4)
    `CHK(p_out[1].ready, 1'b0)
    `CHK(p_out[1].oe, 8'hF0)
    io(1'b0, 1'b1, 1'b1, 8'h40);
    io(1'b0, 1'b1, 1'b1, 8'hB7);
    io(1'b0, 1'b1, 1'b1, 8'hFE);
    fetch(8'h00);
    @(posedge clk) val <= 8'h0E;
    tick(3);
    `CHK(int_oe, 1'b0)
    @(posedge clk) val <= 8'h0F;
    tick(3);
    `CHK(int_oe, 1'b1)
    ack;
    `CHK(q, 8'h40)
    fetch(8'hED);
    fetch(8'h4D);
    `CHK(int_oe, 1'b0)
    @(posedge clk) val <= 8'h0E;
    @(posedge clk) {m1_n, rd_n, d_in} <= 10'h000;
    @(posedge clk) val <= 8'h0F;
    tick(3);
    `CHK(int_oe, 1'b0)
    @(posedge clk) {m1_n, rd_n} <= 2'b11;
    tick(3);
    `CHK(int_oe, 1'b1)
    end_of_test;
  end
endmodule : pph_parallel_port_tb_top
